// >>> hdl/cmso_alu.v
// combinational byte logic: or, negate, nibble swap and the negate overflow and carry flags
// assumes the caller chooses which results to store
`timescale 1ns/10ps
`include "cmso_consts.vh"
module cmso_alu (
   input  wire [7:0] acc,
   input  wire [7:0] opnd,
   input  wire [7:0] flip_src,
   output wire [7:0] or_res,
   output wire [7:0] flip_res,
   output wire       flip_ovf,
   output wire       flip_carry,
   output wire [7:0] swap_res
);
   // RULE3 bitwise inclusive or
   assign or_res     = acc | opnd;
   // RULE12 two's complement, 80 stays put
   assign flip_res   = 8'h00 - flip_src;
   assign flip_ovf   = (flip_src == `CMSO_SIGN_ONLY);
   assign flip_carry = (flip_res != 8'h00);
   // RULE13 exchange the nibbles
   assign swap_res   = {acc[3:0], acc[7:4]};
endmodule // cmso_alu

// >>> hdl/cmso_consts.vh
// constants for the stack, multiply and logic execution slice
// included by every design file of the slice
`ifndef CMSO_CONSTS_VH
`define CMSO_CONSTS_VH
// register map, byte addresses on the ahb-lite bus
`define CMSO_ADDR_ACC      8'h00
`define CMSO_ADDR_IDXL     8'h04
`define CMSO_ADDR_IDXH     8'h08
`define CMSO_ADDR_SP       8'h0c
`define CMSO_ADDR_FLAGS    8'h10
`define CMSO_ADDR_CMD      8'h14
`define CMSO_ADDR_OPND     8'h18
`define CMSO_ADDR_STAT     8'h1c
`define CMSO_ADDR_W        8
// command codes written to the command register
`define CMSO_OP_W          4
`define CMSO_OP_PRODUCT    4'h1
`define CMSO_OP_OR_ACC     4'h2
`define CMSO_OP_FLIP_ACC   4'h3
`define CMSO_OP_FLIP_IDXL  4'h4
`define CMSO_OP_FLIP_MEM   4'h5
`define CMSO_OP_SWAP       4'h6
`define CMSO_OP_PUSH_ACC   4'h7
`define CMSO_OP_PUSH_IDXH  4'h8
`define CMSO_OP_PUSH_IDXL  4'h9
`define CMSO_OP_POP_ACC    4'ha
`define CMSO_OP_POP_IDXH   4'hb
`define CMSO_OP_POP_IDXL   4'hc
// flag register bit positions
`define CMSO_F_C           0
`define CMSO_F_Z           1
`define CMSO_F_N           2
`define CMSO_F_I           3
`define CMSO_F_H           4
`define CMSO_F_V           7
// reset values and the sign-only byte that sets negate overflow
`define CMSO_RST_FLAGS     8'h68
`define CMSO_RST_SP        16'h00ff
`define CMSO_SIGN_ONLY     8'h80
// command register fields
`define CMSO_CMD_GO        8
// multiply takes this many cycles in the iterative unit
`define CMSO_MUL_STEPS     4'h8
`endif

// >>> hdl/cmso_core.v
// execution slice: multiply, or, negate, nibble swap, push and pull
// software drives it over ahb-lite; the stack lives in a local array
`timescale 1ns/10ps
`include "cmso_consts.vh"
// Overview of operation
// RULE1 - multiply forms the unsigned 16-bit product of index low and acc.
// RULE2 - product high byte lands in index low, low byte in the acc.
// RULE3 - or sets each acc bit to acc bit or operand bit.
// RULE4 - or clears overflow, copies bit 7 to negative, keeps h, i and c.
// RULE5 - or sets zero exactly when the result byte is zero.
// RULE6 - push writes the byte at the address held in the stack pointer.
// RULE7 - after a push write the stack pointer goes down by one.
// RULE8 - push keeps its source register and every flag unchanged.
// RULE9 - pull first raises the stack pointer then reads there, flags kept.
// RULE10 - pull to acc loads the read byte into the acc.
// RULE11 - pull to index high loads the read byte into index high.
// RULE12 - negate gives two's complement; 80 stays and sets overflow.
// RULE13 - nibble swap exchanges the acc halves and keeps the flags.
module cmso_core #(
   parameter STACK_AW = 8
) (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output wire        hreadyout,
   output wire        hresp
);
   localparam ST_IDLE = 4'b0001;
   localparam ST_EXEC = 4'b0010;
   localparam ST_MUL  = 4'b0100;
   localparam ST_POP  = 4'b1000;

   localparam STACK_D = 1 << STACK_AW;

   reg [7:0]              acc_q;
   reg [7:0]              idxl_q;
   reg [7:0]              idxh_q;
   reg [7:0]              opnd_q;
   reg [7:0]              flags_q;
   reg [15:0]             sp_q;
   reg [3:0]              op_q;
   reg [3:0]              state_q;
   // the stack wraps within STACK_D bytes; upper pointer bits not decoded
   reg [7:0]              stack_mem [0:STACK_D-1];
   reg [7:0]              pop_byte_q;
   reg                    wr_ph_q;
   reg [`CMSO_ADDR_W-1:0] addr_q;
   reg                    mul_start_q;

   wire [7:0]             or_res;
   wire [7:0]             flip_res;
   wire [7:0]             swap_res;
   wire                   flip_ovf;
   wire                   flip_carry;
   wire [15:0]            product;
   wire                   mul_done;
   wire [7:0]             flip_src;
   wire                   busy;
   wire                   addr_ok;
   wire                   cmd_go;
   wire [STACK_AW-1:0]    sp_idx;
   wire [15:0]            sp_up;

   function is_flip;
      input [3:0] op;
      begin
         is_flip = (op == `CMSO_OP_FLIP_ACC) ||
                   (op == `CMSO_OP_FLIP_IDXL) ||
                   (op == `CMSO_OP_FLIP_MEM);
      end
   endfunction

   function is_push;
      input [3:0] op;
      begin
         is_push = (op == `CMSO_OP_PUSH_ACC) ||
                   (op == `CMSO_OP_PUSH_IDXH) ||
                   (op == `CMSO_OP_PUSH_IDXL);
      end
   endfunction

   function is_pop;
      input [3:0] op;
      begin
         is_pop = (op == `CMSO_OP_POP_ACC) ||
                  (op == `CMSO_OP_POP_IDXH) ||
                  (op == `CMSO_OP_POP_IDXL);
      end
   endfunction

   function is_zero;
      input [7:0] b;
      begin
         is_zero = (b == 8'h00);
      end
   endfunction

   // byte that a push stores, picked from the command code
   function [7:0] push_byte;
      input [3:0] op;
      input [7:0] a;
      input [7:0] h;
      input [7:0] l;
      begin
         case (op)
            `CMSO_OP_PUSH_ACC:  push_byte = a;
            `CMSO_OP_PUSH_IDXH: push_byte = h;
            default:            push_byte = l;
         endcase
      end
   endfunction

   assign flip_src = (op_q == `CMSO_OP_FLIP_ACC)  ? acc_q :
                     (op_q == `CMSO_OP_FLIP_IDXL) ? idxl_q : opnd_q;
   assign busy     = (state_q != ST_IDLE);

   cmso_alu u_alu (
      .acc        (acc_q),
      .opnd       (opnd_q),
      .flip_src   (flip_src),
      .or_res     (or_res),
      .flip_res   (flip_res),
      .flip_ovf   (flip_ovf),
      .flip_carry (flip_carry),
      .swap_res   (swap_res)
   );

   cmso_mult #(.W(8)) u_mult (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .start     (mul_start_q),
      .mcand     (idxl_q),
      .mplier    (acc_q),
      .product_q (product),
      .done_q    (mul_done)
   );

   // bus: zero wait state, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign addr_ok   = hsel & hready & htrans[1];

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ph_q <= 1'b0;
         addr_q  <= {`CMSO_ADDR_W{1'b0}};
      end else begin
         wr_ph_q <= addr_ok & hwrite;
         if (addr_ok)
            addr_q <= haddr[`CMSO_ADDR_W-1:0];
      end
   end

   // read data registered in the address phase, shown in the data phase
   // a read right behind a write to the same register sees the old value
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0;
      end else if (addr_ok & ~hwrite) begin
         case (haddr[`CMSO_ADDR_W-1:0])
            `CMSO_ADDR_ACC:   hrdata <= {24'h0, acc_q};
            `CMSO_ADDR_IDXL:  hrdata <= {24'h0, idxl_q};
            `CMSO_ADDR_IDXH:  hrdata <= {24'h0, idxh_q};
            `CMSO_ADDR_SP:    hrdata <= {16'h0, sp_q};
            `CMSO_ADDR_FLAGS: hrdata <= {24'h0, flags_q};
            `CMSO_ADDR_CMD:   hrdata <= {28'h0, op_q};
            `CMSO_ADDR_OPND:  hrdata <= {24'h0, opnd_q};
            `CMSO_ADDR_STAT:  hrdata <= {31'h0, busy};
            default:          hrdata <= 32'h0;
         endcase
      end
   end

   assign cmd_go = wr_ph_q && (addr_q == `CMSO_ADDR_CMD) && !busy;
   assign sp_idx = sp_q[STACK_AW-1:0];
   assign sp_up  = sp_q + 16'h0001;

   // stack memory write port; no reset, contents are only seen by pulls
   always @(posedge hclk) begin
      // RULE6 byte stored at current stack pointer
      if (state_q == ST_EXEC && is_push(op_q))
         stack_mem[sp_idx] <= push_byte(op_q, acc_q, idxh_q, idxl_q);
   end

   // RULE9 read at the raised pointer sp_up, in the same cycle that raises sp_q
   // the array read costs a cycle, so the pulled byte lands in ST_POP
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         pop_byte_q <= 8'h00;
      else if (state_q == ST_EXEC && is_pop(op_q))
         pop_byte_q <= stack_mem[sp_up[STACK_AW-1:0]];
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q     <= ST_IDLE;
         acc_q       <= 8'h00;
         idxl_q      <= 8'h00;
         idxh_q      <= 8'h00;
         opnd_q      <= 8'h00;
         op_q        <= 4'h0;
         flags_q     <= `CMSO_RST_FLAGS;
         sp_q        <= `CMSO_RST_SP;
         mul_start_q <= 1'b0;
      end else begin
         mul_start_q <= 1'b0;
         // software writes only while idle; busy writes are dropped
         if (wr_ph_q && !busy) begin
            case (addr_q)
               `CMSO_ADDR_ACC:   acc_q   <= hwdata[7:0];
               `CMSO_ADDR_IDXL:  idxl_q  <= hwdata[7:0];
               `CMSO_ADDR_IDXH:  idxh_q  <= hwdata[7:0];
               `CMSO_ADDR_SP:    sp_q    <= hwdata[15:0];
               `CMSO_ADDR_FLAGS: flags_q <= hwdata[7:0];
               `CMSO_ADDR_OPND:  opnd_q  <= hwdata[7:0];
               `CMSO_ADDR_CMD:   op_q    <= hwdata[`CMSO_OP_W-1:0];
               default: ;
            endcase
         end
         case (state_q)
            ST_IDLE: begin
               if (cmd_go && hwdata[`CMSO_CMD_GO])
                  state_q <= ST_EXEC;
            end
            ST_EXEC: begin
               state_q <= ST_IDLE;
               case (op_q)
                  `CMSO_OP_PRODUCT: begin
                     mul_start_q <= 1'b1;
                     state_q     <= ST_MUL;
                  end
                  `CMSO_OP_OR_ACC: begin
                     acc_q <= or_res;
                     // RULE4 v cleared, n from bit 7
                     flags_q[`CMSO_F_V] <= 1'b0;
                     flags_q[`CMSO_F_N] <= or_res[7];
                     // RULE5 zero on empty result
                     flags_q[`CMSO_F_Z] <= is_zero(or_res);
                  end
                  `CMSO_OP_SWAP: acc_q <= swap_res;
                  `CMSO_OP_PUSH_ACC, `CMSO_OP_PUSH_IDXH,
                  `CMSO_OP_PUSH_IDXL: begin
                     // RULE7 pointer down after write
                     // RULE8 source and flags untouched
                     sp_q <= sp_q - 16'h0001;
                  end
                  `CMSO_OP_POP_ACC, `CMSO_OP_POP_IDXH,
                  `CMSO_OP_POP_IDXL: begin
                     // RULE9 pointer up first
                     sp_q    <= sp_up;
                     state_q <= ST_POP;
                  end
                  default: begin
                     if (is_flip(op_q)) begin
                        // RULE12 store negation and flags
                        if (op_q == `CMSO_OP_FLIP_ACC)
                           acc_q <= flip_res;
                        else if (op_q == `CMSO_OP_FLIP_IDXL)
                           idxl_q <= flip_res;
                        else
                           opnd_q <= flip_res;
                        flags_q[`CMSO_F_V] <= flip_ovf;
                        flags_q[`CMSO_F_N] <= flip_res[7];
                        flags_q[`CMSO_F_Z] <= is_zero(flip_res);
                        flags_q[`CMSO_F_C] <= flip_carry;
                     end
                  end
               endcase
            end
            // iterative multiply: eight adder steps instead of an array
            ST_MUL: begin
               if (mul_done) begin
                  // RULE2 high byte to index low, low byte to acc
                  idxl_q  <= product[15:8];
                  acc_q   <= product[7:0];
                  flags_q[`CMSO_F_H] <= 1'b0;
                  flags_q[`CMSO_F_C] <= 1'b0;
                  state_q <= ST_IDLE;
               end
            end
            ST_POP: begin
               state_q <= ST_IDLE;
               // RULE10 pull into acc
               if (op_q == `CMSO_OP_POP_ACC)
                  acc_q <= pop_byte_q;
               // RULE11 pull into index high
               else if (op_q == `CMSO_OP_POP_IDXH)
                  idxh_q <= pop_byte_q;
               else
                  idxl_q <= pop_byte_q;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end
endmodule // cmso_core

// >>> hdl/cmso_mult.v
// shift-and-add 8x8 unsigned multiplier, one bit per cycle
// assumes start is a one-cycle pulse while idle
`timescale 1ns/10ps
`include "cmso_consts.vh"
module cmso_mult #(
   parameter W = 8
) (
   input  wire           hclk,
   input  wire           hresetn,
   input  wire           start,
   input  wire [W-1:0]   mcand,
   input  wire [W-1:0]   mplier,
   output reg  [2*W-1:0] product_q,
   output reg            done_q
);
   reg [W-1:0]   mplier_q;
   reg [2*W-1:0] mcand_q;
   reg [3:0]     cnt_q;
   reg           busy_q;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         product_q <= {2*W{1'b0}};
         mcand_q   <= {2*W{1'b0}};
         mplier_q  <= {W{1'b0}};
         cnt_q     <= 4'h0;
         busy_q    <= 1'b0;
         done_q    <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (start) begin
            product_q <= {2*W{1'b0}};
            mcand_q   <= {{W{1'b0}}, mcand};
            mplier_q  <= mplier;
            cnt_q     <= `CMSO_MUL_STEPS;
            busy_q    <= 1'b1;
         end else if (busy_q) begin
            // RULE1 unsigned partial sums
            if (mplier_q[0])
               product_q <= product_q + mcand_q;
            mcand_q  <= {mcand_q[2*W-2:0], 1'b0};
            mplier_q <= {1'b0, mplier_q[W-1:1]};
            cnt_q    <= cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
         end
      end
   end
endmodule // cmso_mult

// >>> sim/cmso_core_properties.sv
// port assertions for the stack, multiply and logic execution slice
// bound to cmso_core from the testbench top file; one clock domain
`timescale 1ns/10ps
`include "cmso_consts.vh"
module cmso_core_properties (
   input wire        hclk,
   input wire        hresetn,
   input wire        hsel,
   input wire [31:0] haddr,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire [31:0] hrdata,
   input wire        hreadyout,
   input wire        hresp
);
   logic       rd_q;
   logic [7:0] ad_q;

   // marks the data phase of a read and keeps its address
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_q <= 1'b0;
         ad_q <= 8'h00;
      end else begin
         rd_q <= hsel & hready & htrans[1] & !hwrite;
         ad_q <= haddr[7:0];
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_ready_high: assert property (hreadyout)
      else $error("hreadyout low");
   a_resp_okay: assert property (!hresp)
      else $error("error response");
   a_rdata_hold: assert property (!rd_q |-> $stable(hrdata))
      else $error("read data moved without a read");
   a_reset_zero: assert property ($rose(hresetn) |-> hrdata == 32'h0)
      else $error("read data not cleared by reset");
   a_byte_upper: assert property (rd_q && ad_q != `CMSO_ADDR_SP &&
      ad_q != `CMSO_ADDR_CMD |-> hrdata[31:8] == 24'h0)
      else $error("byte register shows upper bits");
   a_sp_upper: assert property (rd_q && ad_q == `CMSO_ADDR_SP
      |-> hrdata[31:16] == 16'h0)
      else $error("stack pointer wider than 16 bits");
   a_stat_bits: assert property (rd_q && ad_q == `CMSO_ADDR_STAT
      |-> hrdata[31:1] == 31'h0)
      else $error("status shows more than busy");
   a_unmapped_zero: assert property (rd_q && ad_q > `CMSO_ADDR_STAT
      |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
endmodule // cmso_core_properties

// >>> sim/cmso_core_test.sv
// self-checking bench for the execution slice, driven over ahb-lite
// assumes a zero-wait slave; hsize is tied to word
`timescale 1ns/10ps
`include "cmso_consts.vh"
module cmso_core_test;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   int          errors = 0;
   int          checked = 0;

   cmso_core cmso_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp));

   always #20 hclk = ~hclk;

   task test_done;
      if (errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, seen, exp);
      end
   endtask

   // one single transfer; holds each phase until hready is seen high
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr  <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] v;
      xfer(1'b1, a, d, v);
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      logic [31:0] v;
      xfer(1'b0, a, 32'h0, v);
      chk(v, {16'h0, exp});
   endtask

   // commands are only sent while idle, so poll busy afterwards
   task automatic op(input logic [3:0] c);
      logic [31:0] v;
      wr(`CMSO_ADDR_CMD, {23'h0, 1'b1, 4'h0, c});
      do xfer(1'b0, `CMSO_ADDR_STAT, 32'h0, v); while (v[0] !== 1'b0);
   endtask

   task t_reset;
      rd(`CMSO_ADDR_ACC, 16'h0);
      rd(`CMSO_ADDR_IDXL, 16'h0);
      rd(`CMSO_ADDR_IDXH, 16'h0);
      rd(`CMSO_ADDR_SP, `CMSO_RST_SP);
      rd(`CMSO_ADDR_FLAGS, {8'h0, `CMSO_RST_FLAGS});
      rd(`CMSO_ADDR_STAT, 16'h0);
      wr(8'h20, 32'h5a);
      rd(8'h20, 16'h0);
   endtask

   task automatic t_mul;
      logic [7:0]  x, a;
      logic [15:0] p;
      for (int i = 0; i < 3; i++) begin
         x = 8'hff >> (4 * i);
         a = 8'hff - 8'h11 * i[7:0];
         p = {8'h0, x} * {8'h0, a};
         wr(`CMSO_ADDR_IDXL, {24'h0, x});
         wr(`CMSO_ADDR_ACC, {24'h0, a});
         wr(`CMSO_ADDR_FLAGS, 32'hff);
         op(`CMSO_OP_PRODUCT);
         rd(`CMSO_ADDR_IDXL, {8'h0, p[15:8]});
         rd(`CMSO_ADDR_ACC, {8'h0, p[7:0]});
         rd(`CMSO_ADDR_FLAGS, 16'hee);
      end
   endtask

   task automatic t_or;
      logic [7:0] a, f, r;
      for (int i = 0; i < 3; i++) begin
         a = 8'h40 * i[7:0];
         f = i[0] ? 8'h00 : 8'hff;
         r = a | i[7:0];
         wr(`CMSO_ADDR_ACC, {24'h0, a});
         wr(`CMSO_ADDR_OPND, i);
         wr(`CMSO_ADDR_FLAGS, {24'h0, f});
         op(`CMSO_OP_OR_ACC);
         rd(`CMSO_ADDR_ACC, {8'h0, r});
         rd(`CMSO_ADDR_FLAGS, {8'h0, (f & 8'h79) |
            {5'h0, r[7], r == 8'h00, 1'b0}});
      end
   endtask

   task automatic t_neg;
      logic [7:0]  ad, v;
      logic [31:0] q;
      for (int j = 0; j < 6; j++) begin
         ad = (j < 2) ? `CMSO_ADDR_ACC :
              (j < 4) ? `CMSO_ADDR_IDXL : `CMSO_ADDR_OPND;
         v = j[0] ? 8'h01 : `CMSO_SIGN_ONLY;
         wr(ad, {24'h0, v});
         op(`CMSO_OP_FLIP_ACC + {1'b0, j[3:1]});
         rd(ad, {8'h0, 8'h00 - v});
         xfer(1'b0, `CMSO_ADDR_FLAGS, 32'h0, q);
         chk({31'h0, q[7]}, {31'h0, !j[0]});
         chk({29'h0, q[2:0]}, 32'h5);
      end
   endtask

   task t_swap;
      wr(`CMSO_ADDR_ACC, 32'ha5);
      wr(`CMSO_ADDR_FLAGS, 32'h9a);
      op(`CMSO_OP_SWAP);
      rd(`CMSO_ADDR_ACC, 16'h5a);
      rd(`CMSO_ADDR_FLAGS, 16'h9a);
   endtask

   task automatic t_stack;
      logic [7:0] ad, v;
      wr(`CMSO_ADDR_SP, 32'h40);
      wr(`CMSO_ADDR_FLAGS, 32'h8b);
      for (int i = 0; i < 3; i++) begin
         ad = (i == 0) ? `CMSO_ADDR_ACC :
              (i == 1) ? `CMSO_ADDR_IDXH : `CMSO_ADDR_IDXL;
         v = 8'h11 * i[7:0] + 8'h11;
         wr(ad, {24'h0, v});
         op(`CMSO_OP_PUSH_ACC + i[3:0]);
         rd(`CMSO_ADDR_SP, 16'h3f - i[15:0]);
         rd(ad, {8'h0, v});
      end
      rd(`CMSO_ADDR_FLAGS, 16'h8b);
      wr(`CMSO_ADDR_ACC, 32'h0);
      wr(`CMSO_ADDR_IDXH, 32'h0);
      wr(`CMSO_ADDR_IDXL, 32'h0);
      op(`CMSO_OP_POP_IDXL);
      rd(`CMSO_ADDR_SP, 16'h3e);
      rd(`CMSO_ADDR_IDXL, 16'h33);
      op(`CMSO_OP_POP_IDXH);
      rd(`CMSO_ADDR_IDXH, 16'h22);
      op(`CMSO_OP_POP_ACC);
      rd(`CMSO_ADDR_ACC, 16'h11);
      rd(`CMSO_ADDR_SP, 16'h40);
      rd(`CMSO_ADDR_FLAGS, 16'h8b);
   endtask

   // go clear only stores the code; writes during a multiply are dropped
   task automatic t_cmd;
      logic [31:0] v;
      wr(`CMSO_ADDR_ACC, 32'h12);
      wr(`CMSO_ADDR_CMD, {28'h0, `CMSO_OP_SWAP});
      rd(`CMSO_ADDR_CMD, {12'h0, `CMSO_OP_SWAP});
      rd(`CMSO_ADDR_ACC, 16'h12);
      wr(`CMSO_ADDR_IDXL, 32'h03);
      wr(`CMSO_ADDR_ACC, 32'h05);
      wr(`CMSO_ADDR_CMD, {23'h0, 1'b1, 4'h0, `CMSO_OP_PRODUCT});
      wr(`CMSO_ADDR_ACC, 32'haa);
      do xfer(1'b0, `CMSO_ADDR_STAT, 32'h0, v); while (v[0] !== 1'b0);
      rd(`CMSO_ADDR_ACC, 16'h0f);
      rd(`CMSO_ADDR_IDXL, 16'h00);
   endtask

   // the whole run needs well under two thousand cycles
   initial begin
      repeat (20000) @(posedge hclk);
      errors++;
      test_done;
   end

   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_mul;
      t_or;
      t_neg;
      t_swap;
      t_stack;
      t_cmd;
      test_done;
   end
endmodule // cmso_core_test

bind cmso_core cmso_core_properties cmso_core_properties_i (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp));
